// >>> adc_seq_params.svh
/*
  Register offsets, field positions and reset values of the conversion sequencer.
  Assumes byte addresses on an 8-bit register port with 32-bit data.
*/
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// ============================================================
// Register offsets
`define ADC_OFS_START 8'h00
`define ADC_OFS_TRIG 8'h04
`define ADC_OFS_MODE 8'h08
`define ADC_OFS_CHAN 8'h0C
`define ADC_OFS_FLAGS 8'h10
`define ADC_OFS_SLOT0 8'h20
`define ADC_OFS_PRIO_RES 8'h40

// ============================================================
// Field positions
`define ADC_START_NORMAL 0
`define ADC_START_PRIO 1
`define ADC_TRIG_NORM_EN 0
`define ADC_TRIG_PRIO_EN 1
`define ADC_TRIG_NORM_SRC 2
`define ADC_TRIG_PRIO_SRC 3
`define ADC_TRIG_DUAL 4
`define ADC_TRIG_DSEL_LO 5
`define ADC_MODE_SCAN 0
`define ADC_MODE_REPEAT 1
`define ADC_MODE_ITM_LO 2
`define ADC_CHAN_FIX_LO 0
`define ADC_CHAN_PRIO_LO 4
`define ADC_CHAN_SSTA_LO 8
`define ADC_CHAN_SCNT_LO 12
`define ADC_FLAG_EOC 0
`define ADC_FLAG_BUSY 1
`define ADC_FLAG_PEOC 2
`define ADC_FLAG_PBUSY 3
`define ADC_RES_VALID 31
`define ADC_RES_OVR 30

// ============================================================
// Reset values and encodings
`define ADC_TRIG_RST 7'h00
`define ADC_MODE_RST 5'h00
`define ADC_CHAN_RST 16'h0000
`define ADC_DSEL_EXT 2'h1
`define ADC_DSEL_TIMER 2'h2
`define ADC_SLOTS 8

`endif

// >>> adc_seq_pkg.sv
/*
  Types shared by the conversion sequencer.
  Assumes adc_seq_params.svh supplies the numeric constants.
*/
package adc_seq_pkg;
  typedef enum logic [1:0] {S_IDLE, S_NORM, S_PRIO} seq_state_e;
  typedef enum logic [1:0] {
    MODE_FIX_SINGLE = 2'h0,
    MODE_SCAN_SINGLE = 2'h1,
    MODE_FIX_REPEAT = 2'h2,
    MODE_SCAN_REPEAT = 2'h3
  } conv_mode_e;
  typedef logic [3:0] chan_t;
endpackage

// >>> adc_conversion_sequencer.sv
/*
  Sequencer for one converter unit: normal and top-priority conversions, flags,
  result slots and completion requests.
  Assumes an external converter core that takes conv_start with conv_channel,
  drops the conversion on conv_abort, and answers with a one-cycle conv_done
  no earlier than the cycle after conv_start.
*/
// Operation
// - Normal software start begins selected-mode conversion.
// - Priority software start begins priority conversion.
// - Four normal modes; priority always fixed single.
// - Source zero uses pin; dual mode selects trigger.
// - Hardware starts need their own enable bit.
// - Software start still works with hardware enabled.
// - Normal start sets normal busy.
// - Priority start sets priority busy, keeps normal flags.
// - Priority pre-empts normal, which resumes same channel.
// - Hardware priority trigger pre-empts the same way.
// - Clearing repeat ends a fixed run after current conversion, a scan after its last channel.
// - New normal start aborts, clears flags, restarts.
// - Fixed single completion: flag, idle, interrupt, store.
// - Scan single: flags and interrupt after whole scan.
// - Results by channel; slots four-seven repeat only.
// - Fixed repeat keeps busy; interval one stores slot zero.
// - Interval eight fills slots zero-seven then wraps.
// - Scan repeat: flag, interrupt, restart; count field plus one.
// - Channel from fixed field or scan fields.
// - Repeat and scan encode the four modes.
// - Priority completion sets its flag and interrupt.
// - Reading a completion flag clears it.
`include "adc_seq_params.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_sequencer #(
  parameter int DATA_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Hardware triggers
  input wire logic ext_trigger_pin,
  input wire logic timer_trigger,
  // Converter core
  output logic conv_start,
  output logic conv_abort,
  output adc_seq_pkg::chan_t conv_channel,
  input wire logic conv_done,
  input wire logic [DATA_W-1:0] conv_data,
  // Completion requests
  output logic unit_a_done_irq,
  output logic unit_a_priority_done_irq
);
  import adc_seq_pkg::*;

  // ============================================================
  // State
  seq_state_e state, next_state;
  logic normal_hw_trigger_en, next_normal_hw_trigger_en;
  logic priority_hw_trigger_en, next_priority_hw_trigger_en;
  logic normal_hw_source_sel, next_normal_hw_source_sel;
  logic priority_hw_source_sel, next_priority_hw_source_sel;
  logic dual_unit_mode, next_dual_unit_mode;
  logic [1:0] dual_trigger_select, next_dual_trigger_select;
  logic scan_bit, next_scan_bit;
  logic repeat_bit, next_repeat_bit;
  logic [2:0] itm, next_itm;
  chan_t fixed_channel_sel, next_fixed_channel_sel;
  chan_t priority_channel_sel, next_priority_channel_sel;
  chan_t scan_start_channel, next_scan_start_channel;
  logic [3:0] scan_channel_count, next_scan_channel_count;
  logic eoc_flag, next_eoc_flag;
  logic busy_flag, next_busy_flag;
  logic prio_eoc_flag, next_prio_eoc_flag;
  logic prio_busy_flag, next_prio_busy_flag;
  chan_t cur_ch, next_cur_ch;
  logic [2:0] rep_cnt, next_rep_cnt;
  logic [DATA_W-1:0] res_data [`ADC_SLOTS];
  logic [DATA_W-1:0] next_res_data [`ADC_SLOTS];
  logic [`ADC_SLOTS-1:0] result_valid_flag, next_result_valid_flag;
  logic [`ADC_SLOTS-1:0] result_overrun_flag, next_result_overrun_flag;
  logic [DATA_W-1:0] prio_data, next_prio_data;
  logic ext_prev;
  logic [31:0] next_reg_rdata;
  logic next_conv_start, next_conv_abort;
  chan_t next_conv_channel;
  logic next_done_irq, next_prio_irq;

  // ============================================================
  // Trigger decode
  logic ext_rise, normal_sw_start, priority_sw_start, normal_go, prio_go;

  // Source select 0 means the pin (or, in dual mode, the selected trigger); 1 means the timer.
  function automatic logic hw_event(input logic src, input logic dual, input logic [1:0] dsel,
                                    input logic ext, input logic tmr);
    if (src) return tmr;
    if (!dual) return ext;
    return (dsel == `ADC_DSEL_EXT) ? ext : ((dsel == `ADC_DSEL_TIMER) ? tmr : 1'b0);
  endfunction

  // Slot index of a result address, or 8 when the address is not a slot.
  function automatic logic [3:0] slot_of(input logic [7:0] a);
    if (a >= `ADC_OFS_SLOT0 && a < `ADC_OFS_PRIO_RES && a[1:0] == 2'h0)
      return {1'b0, 3'(a[4:2])};
    return 4'h8;
  endfunction

  assign ext_rise = ext_trigger_pin & ~ext_prev;
  assign normal_sw_start = reg_wr && reg_addr == `ADC_OFS_START && reg_wdata[`ADC_START_NORMAL];
  assign priority_sw_start = reg_wr && reg_addr == `ADC_OFS_START && reg_wdata[`ADC_START_PRIO];
  // Software starts stay live beside hardware ones.
  assign normal_go = normal_sw_start || (normal_hw_trigger_en &&
    hw_event(normal_hw_source_sel, dual_unit_mode, dual_trigger_select, ext_rise, timer_trigger));
  assign prio_go = priority_sw_start || (priority_hw_trigger_en &&
    hw_event(priority_hw_source_sel, dual_unit_mode, dual_trigger_select, ext_rise, timer_trigger));

  // ============================================================
  // Next-state logic
  always_comb begin
    logic [2:0] slot;
    logic last_ch;
    logic [3:0] rs;
    slot = 3'h0;
    last_ch = (cur_ch == chan_t'(scan_start_channel + scan_channel_count));
    rs = slot_of(reg_addr);
    next_state = state;
    next_normal_hw_trigger_en = normal_hw_trigger_en;
    next_priority_hw_trigger_en = priority_hw_trigger_en;
    next_normal_hw_source_sel = normal_hw_source_sel;
    next_priority_hw_source_sel = priority_hw_source_sel;
    next_dual_unit_mode = dual_unit_mode;
    next_dual_trigger_select = dual_trigger_select;
    next_scan_bit = scan_bit;
    next_repeat_bit = repeat_bit;
    next_itm = itm;
    next_fixed_channel_sel = fixed_channel_sel;
    next_priority_channel_sel = priority_channel_sel;
    next_scan_start_channel = scan_start_channel;
    next_scan_channel_count = scan_channel_count;
    next_eoc_flag = eoc_flag;
    next_busy_flag = busy_flag;
    next_prio_eoc_flag = prio_eoc_flag;
    next_prio_busy_flag = prio_busy_flag;
    next_cur_ch = cur_ch;
    next_rep_cnt = rep_cnt;
    next_res_data = res_data;
    next_result_valid_flag = result_valid_flag;
    next_result_overrun_flag = result_overrun_flag;
    next_prio_data = prio_data;
    next_conv_start = 1'b0;
    next_conv_abort = 1'b0;
    next_conv_channel = conv_channel;
    next_done_irq = 1'b0;
    next_prio_irq = 1'b0;
    next_reg_rdata = 32'h0000_0000;

    // Reads: data for the next cycle, then read side effects (any set below wins).
    if (reg_rd) begin
      if (reg_addr == `ADC_OFS_TRIG)
        next_reg_rdata = {25'h0, dual_trigger_select, dual_unit_mode, priority_hw_source_sel,
                          normal_hw_source_sel, priority_hw_trigger_en, normal_hw_trigger_en};
      else if (reg_addr == `ADC_OFS_MODE)
        next_reg_rdata = {27'h0, itm, repeat_bit, scan_bit};
      else if (reg_addr == `ADC_OFS_CHAN)
        next_reg_rdata = {16'h0, scan_channel_count, scan_start_channel, priority_channel_sel,
                          fixed_channel_sel};
      else if (reg_addr == `ADC_OFS_FLAGS) begin
        next_reg_rdata = {28'h0, prio_busy_flag, prio_eoc_flag, busy_flag, eoc_flag};
        next_eoc_flag = 1'b0;
        next_prio_eoc_flag = 1'b0;
      end else if (reg_addr == `ADC_OFS_PRIO_RES)
        next_reg_rdata = {32'(prio_data)};
      else if (!rs[3]) begin
        next_reg_rdata = {result_valid_flag[rs[2:0]], result_overrun_flag[rs[2:0]],
                          30'(res_data[rs[2:0]])};
        next_result_valid_flag[rs[2:0]] = 1'b0;
        next_result_overrun_flag[rs[2:0]] = 1'b0;
      end
    end

    // Configuration writes.
    if (reg_wr) begin
      if (reg_addr == `ADC_OFS_TRIG) begin
        next_normal_hw_trigger_en = reg_wdata[`ADC_TRIG_NORM_EN];
        next_priority_hw_trigger_en = reg_wdata[`ADC_TRIG_PRIO_EN];
        next_normal_hw_source_sel = reg_wdata[`ADC_TRIG_NORM_SRC];
        next_priority_hw_source_sel = reg_wdata[`ADC_TRIG_PRIO_SRC];
        next_dual_unit_mode = reg_wdata[`ADC_TRIG_DUAL];
        next_dual_trigger_select = reg_wdata[`ADC_TRIG_DSEL_LO +: 2];
      end else if (reg_addr == `ADC_OFS_MODE) begin
        next_scan_bit = reg_wdata[`ADC_MODE_SCAN];
        next_repeat_bit = reg_wdata[`ADC_MODE_REPEAT];
        next_itm = reg_wdata[`ADC_MODE_ITM_LO +: 3];
      end else if (reg_addr == `ADC_OFS_CHAN) begin
        next_fixed_channel_sel = reg_wdata[`ADC_CHAN_FIX_LO +: 4];
        next_priority_channel_sel = reg_wdata[`ADC_CHAN_PRIO_LO +: 4];
        next_scan_start_channel = reg_wdata[`ADC_CHAN_SSTA_LO +: 4];
        next_scan_channel_count = reg_wdata[`ADC_CHAN_SCNT_LO +: 4];
      end
    end

    // Normal completion; the mode bits at completion decide, so a cleared repeat bit ends the run.
    if (conv_done && state == S_NORM) begin
      next_state = S_IDLE;
      slot = (repeat_bit && !scan_bit) ? rep_cnt : {1'b0, cur_ch[1:0]};
      next_res_data[slot] = conv_data;
      next_result_overrun_flag[slot] = result_valid_flag[slot];
      next_result_valid_flag[slot] = 1'b1;
      unique case (conv_mode_e'({repeat_bit, scan_bit}))
        MODE_FIX_SINGLE: begin
          next_eoc_flag = 1'b1;
          next_busy_flag = 1'b0;
          next_done_irq = 1'b1;
        end
        MODE_SCAN_SINGLE: begin
          if (last_ch) begin
            next_eoc_flag = 1'b1;
            next_busy_flag = 1'b0;
            next_done_irq = 1'b1;
          end else
            next_cur_ch = cur_ch + 4'h1;
        end
        MODE_FIX_REPEAT: begin
          if (rep_cnt == itm) begin
            next_eoc_flag = 1'b1;
            next_done_irq = 1'b1;
            next_rep_cnt = 3'h0;
          end else
            next_rep_cnt = rep_cnt + 3'h1;
        end
        MODE_SCAN_REPEAT: begin
          if (last_ch) begin
            next_eoc_flag = 1'b1;
            next_done_irq = 1'b1;
            next_cur_ch = scan_start_channel;
          end else
            next_cur_ch = cur_ch + 4'h1;
        end
      endcase
    end

    // Priority completion.
    if (conv_done && state == S_PRIO) begin
      next_state = S_IDLE;
      next_prio_data = conv_data;
      next_prio_eoc_flag = 1'b1;
      next_prio_busy_flag = 1'b0;
      next_prio_irq = 1'b1;
    end

    // A new normal start aborts the one in flight and clears its status.
    if (normal_go) begin
      next_busy_flag = 1'b1;
      next_eoc_flag = 1'b0;
      next_done_irq = 1'b0;
      next_result_valid_flag = '0;
      next_result_overrun_flag = '0;
      next_cur_ch = scan_bit ? scan_start_channel : fixed_channel_sel;
      next_rep_cnt = 3'h0;
      if (state == S_NORM && !conv_done) begin
        next_conv_abort = 1'b1;
        next_state = S_IDLE;
      end
    end

    // A priority start pre-empts without touching the normal channel pointer or flags.
    if (prio_go) begin
      next_prio_busy_flag = 1'b1;
      if (state != S_IDLE && !conv_done) begin
        next_conv_abort = 1'b1;
        next_state = S_IDLE;
      end
    end

    // Issue: pending priority first, then the suspended or running normal sequence.
    if (state == S_IDLE && !normal_go && !prio_go) begin
      if (prio_busy_flag) begin
        next_state = S_PRIO;
        next_conv_start = 1'b1;
        next_conv_channel = priority_channel_sel;
      end else if (busy_flag) begin
        next_state = S_NORM;
        next_conv_start = 1'b1;
        next_conv_channel = cur_ch;
      end
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      {dual_trigger_select, dual_unit_mode, priority_hw_source_sel, normal_hw_source_sel,
       priority_hw_trigger_en, normal_hw_trigger_en} <= `ADC_TRIG_RST;
      {itm, repeat_bit, scan_bit} <= `ADC_MODE_RST;
      {scan_channel_count, scan_start_channel, priority_channel_sel, fixed_channel_sel} <= `ADC_CHAN_RST;
      eoc_flag <= 1'b0;
      busy_flag <= 1'b0;
      prio_eoc_flag <= 1'b0;
      prio_busy_flag <= 1'b0;
      cur_ch <= '0;
      rep_cnt <= 3'h0;
      res_data <= '{default: '0};
      result_valid_flag <= '0;
      result_overrun_flag <= '0;
      prio_data <= '0;
      ext_prev <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conv_channel <= '0;
      unit_a_done_irq <= 1'b0;
      unit_a_priority_done_irq <= 1'b0;
    end else begin
      state <= next_state;
      normal_hw_trigger_en <= next_normal_hw_trigger_en;
      priority_hw_trigger_en <= next_priority_hw_trigger_en;
      normal_hw_source_sel <= next_normal_hw_source_sel;
      priority_hw_source_sel <= next_priority_hw_source_sel;
      dual_unit_mode <= next_dual_unit_mode;
      dual_trigger_select <= next_dual_trigger_select;
      scan_bit <= next_scan_bit;
      repeat_bit <= next_repeat_bit;
      itm <= next_itm;
      fixed_channel_sel <= next_fixed_channel_sel;
      priority_channel_sel <= next_priority_channel_sel;
      scan_start_channel <= next_scan_start_channel;
      scan_channel_count <= next_scan_channel_count;
      eoc_flag <= next_eoc_flag;
      busy_flag <= next_busy_flag;
      prio_eoc_flag <= next_prio_eoc_flag;
      prio_busy_flag <= next_prio_busy_flag;
      cur_ch <= next_cur_ch;
      rep_cnt <= next_rep_cnt;
      res_data <= next_res_data;
      result_valid_flag <= next_result_valid_flag;
      result_overrun_flag <= next_result_overrun_flag;
      prio_data <= next_prio_data;
      ext_prev <= ext_trigger_pin;
      reg_rdata <= next_reg_rdata;
      conv_start <= next_conv_start;
      conv_abort <= next_conv_abort;
      conv_channel <= next_conv_channel;
      unit_a_done_irq <= next_done_irq;
      unit_a_priority_done_irq <= next_prio_irq;
    end
  end

  // ============================================================
  // Assertions
  a_normal_start_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    normal_go |=> busy_flag && !eoc_flag) else $error("normal start did not set busy");
  a_prio_start_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    prio_go && !normal_go && !conv_done |=> prio_busy_flag && busy_flag == $past(busy_flag))
    else $error("priority start disturbed normal busy");
  a_prio_preempt_seq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state == S_NORM && prio_go && !normal_go && !conv_done |=> conv_abort ##1
    (conv_start && conv_channel == $past(priority_channel_sel, 2) && state == S_PRIO))
    else $error("priority pre-emption sequence wrong");
  a_restart_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    normal_go |=> result_valid_flag == '0 && result_overrun_flag == '0)
    else $error("restart left result flags set");
  a_single_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_done && state == S_NORM && !repeat_bit && !scan_bit && !normal_go
    |=> !busy_flag && eoc_flag && unit_a_done_irq) else $error("single completion wrong");
  a_repeat_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_done && state == S_NORM && repeat_bit |=> busy_flag)
    else $error("repeat mode dropped busy");
  a_prio_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_done && state == S_PRIO && !prio_go
    |=> prio_eoc_flag && !prio_busy_flag && unit_a_priority_done_irq && prio_data == $past(conv_data))
    else $error("priority completion wrong");
  a_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd && reg_addr == `ADC_OFS_FLAGS && !conv_done |=> !eoc_flag && !prio_eoc_flag)
    else $error("flag read did not clear");
  a_hw_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !normal_hw_trigger_en && !normal_sw_start && !busy_flag |=> !busy_flag)
    else $error("normal start without enable");
  a_repeat_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_done && state == S_NORM && repeat_bit && !scan_bit && !normal_go && rep_cnt == itm
    |=> rep_cnt == 3'h0 && eoc_flag) else $error("repeat slot wrap wrong");
endmodule // adc_conversion_sequencer

`default_nettype wire

// >>> adc_core_model.sv
/*
  Behavioural converter core facing the sequencer.
  Assumes one clock; answers LAT cycles after conv_start unless aborted.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_core_model #(
  parameter int LAT = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Sequencer side
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire adc_seq_pkg::chan_t conv_channel,
  output logic conv_done,
  output logic [11:0] conv_data
);
  import adc_seq_pkg::*;
  int cnt;
  logic [7:0] seq;
  chan_t ch;
  // Data carry {sequence, channel}; outside a result the bus toggles every cycle.
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (!rst_n) begin
      cnt <= 0;
      seq <= 8'h00;
      conv_data <= 12'h000;
    end else if (conv_abort) begin
      cnt <= 0;
    end else if (conv_start) begin
      cnt <= LAT;
      ch <= conv_channel;
    end else if (cnt == 1) begin
      cnt <= 0;
      conv_done <= 1'b1;
      conv_data <= {seq, ch};
      seq <= seq + 8'h01;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule // adc_core_model
`default_nettype wire

// >>> tb_adc_conversion_sequencer.sv
/*
  Self-checking bench of the conversion sequencer.
  Assumes the register map of adc_seq_params.svh and the core model beside it.
*/
`include "adc_seq_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, ext, tmr, cs, ca, cd, irq, pirq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [11:0] cdat;
  chan_t cch;
  int mismatches = 0, num_checks = 0, n_irq = 0, n_pirq = 0, n_done = 0, t;
  adc_conversion_sequencer dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_trigger_pin(ext), .timer_trigger(tmr), .conv_start(cs), .conv_abort(ca),
    .conv_channel(cch), .conv_done(cd), .conv_data(cdat), .unit_a_done_irq(irq),
    .unit_a_priority_done_irq(pirq));
  adc_core_model core_u (.sys_clk(sys_clk), .rst_n(rst_n), .conv_start(cs), .conv_abort(ca),
    .conv_channel(cch), .conv_done(cd), .conv_data(cdat));
  // ============================================================
  // Clock, event counters
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (irq === 1'b1) n_irq <= n_irq + 1;
    if (pirq === 1'b1) n_pirq <= n_pirq + 1;
    if (cd === 1'b1) n_done <= n_done + 1;
  end
  // ============================================================
  // Tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, d);
    chk($sformatf("reg %h", a), e, d & m);
  endtask
  task automatic wait_irq(input bit p);
    int tgt;
    tgt = (p ? n_pirq : n_irq) + 1;
    for (int i = 0; i < 400; i++) begin
      @(negedge sys_clk);
      if ((p ? n_pirq : n_irq) >= tgt) return;
    end
    chk("irq wait", 32'h1, 32'h0);
  endtask
  task automatic pin_edge();
    @(posedge sys_clk);
    ext <= 1'b1;
    @(posedge sys_clk);
    ext <= 1'b0;
  endtask
  task automatic tmr_pulse();
    @(posedge sys_clk);
    tmr <= 1'b1;
    @(posedge sys_clk);
    tmr <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end
  // ============================================================
  // Tests
  initial begin
    {rst_n, reg_wr, reg_rd, ext, tmr} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h0);
    wr(`ADC_OFS_CHAN, 32'h3);
    wr(`ADC_OFS_START, 32'h1);
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h2);
    wait_irq(0);
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h1);
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h0);
    chk_rd(`ADC_OFS_SLOT0 + 8'h0C, 32'h8000000F, 32'h80000003);
    wr(`ADC_OFS_CHAN, 32'h2100);
    wr(`ADC_OFS_MODE, 32'h1);
    t = n_done;
    wr(`ADC_OFS_START, 32'h1);
    wait_irq(0);
    chk("scan count", 32'd3, n_done - t);
    for (int c = 1; c < 4; c++) chk_rd(8'(`ADC_OFS_SLOT0 + 4 * c), 32'hF, c);
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h1);
    wr(`ADC_OFS_MODE, 32'h3);
    wr(`ADC_OFS_CHAN, 32'h52);
    t = n_irq;
    wr(`ADC_OFS_START, 32'h2);
    wait_irq(1);
    chk("single prio", t, n_irq);
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h4);
    chk_rd(`ADC_OFS_PRIO_RES, 32'hF, 32'h5);
    wr(`ADC_OFS_MODE, 32'h2);
    wr(`ADC_OFS_START, 32'h1);
    wait_irq(0);
    chk_rd(`ADC_OFS_SLOT0, 32'h8000000F, 32'h80000002);
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h3);
    wr(`ADC_OFS_START, 32'h2);
    wait_irq(1);
    chk_rd(`ADC_OFS_PRIO_RES, 32'hF, 32'h5);
    wait_irq(0);
    wr(`ADC_OFS_MODE, 32'h0);
    wait_irq(0);
    t = n_irq;
    repeat (30) @(posedge sys_clk);
    chk("stopped", t, n_irq);
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h5);
    wr(`ADC_OFS_MODE, 32'h1E);
    t = n_done;
    wr(`ADC_OFS_START, 32'h1);
    wait_irq(0);
    chk("eight", 32'd8, n_done - t);
    chk_rd(`ADC_OFS_SLOT0 + 8'h1C, 32'h8000000F, 32'h80000002);
    wr(`ADC_OFS_START, 32'h1);
    chk_rd(`ADC_OFS_SLOT0 + 8'h18, 32'h80000000, 32'h0);
    wr(`ADC_OFS_MODE, 32'h0);
    wait_irq(0);
    rd(`ADC_OFS_FLAGS, d);
    wr(`ADC_OFS_CHAN, 32'h1152);
    wr(`ADC_OFS_MODE, 32'h3);
    t = n_done;
    wr(`ADC_OFS_START, 32'h1);
    wait_irq(0);
    chk("scan repeat", 32'd2, n_done - t);
    wait_irq(0);
    chk("scan again", 32'd4, n_done - t);
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h3);
    wr(`ADC_OFS_MODE, 32'h0);
    wait_irq(0);
    chk_rd(`ADC_OFS_FLAGS, 32'hF, 32'h1);
    t = n_irq;
    wr(`ADC_OFS_TRIG, 32'h8);
    pin_edge();
    tmr_pulse();
    repeat (30) @(posedge sys_clk);
    chk("hw off", t, n_irq);
    wr(`ADC_OFS_TRIG, 32'h9);
    pin_edge();
    wait_irq(0);
    wr(`ADC_OFS_START, 32'h1);
    wait_irq(0);
    wr(`ADC_OFS_TRIG, 32'h5);
    tmr_pulse();
    wait_irq(0);
    wr(`ADC_OFS_TRIG, 32'h39);
    pin_edge();
    wait_irq(0);
    wr(`ADC_OFS_TRIG, 32'h51);
    tmr_pulse();
    wait_irq(0);
    t = n_irq;
    wr(`ADC_OFS_TRIG, 32'h19);
    pin_edge();
    tmr_pulse();
    repeat (30) @(posedge sys_clk);
    chk("dual sw only", t, n_irq);
    wr(`ADC_OFS_TRIG, 32'h6);
    wr(`ADC_OFS_START, 32'h1);
    pin_edge();
    wait_irq(1);
    wait_irq(0);
    end_sim();
  end
endmodule // tb_adc_conversion_sequencer
`default_nettype wire
